// ---- hdl/frs_flash_row_erase.sv ----
// flash row erase sequencer: apb registers, unlock check, set-up, stall, latch reset
// assumes a core that honours o_nop_force and o_cpu_stall, and a flash array
// that erases the row on o_erase_busy and clears latches on o_latch_reset
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module frs_flash_row_erase
    import frs_pkg::*;
#(
    parameter int ERASE_CYCLES = FRS_ERASE_CYCLES
)
(
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_sys_rst,
    // apb slave
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [7:0]                i_paddr,
    input  wire logic [31:0]               i_pwdata,
    output logic                           o_pready,
    output logic [31:0]                    o_prdata,
    output logic                           o_pslverr,
    // core control
    output logic                           o_nop_force,
    output logic                           o_cpu_stall,
    output logic                           o_resume,
    // flash array
    output logic                           o_erase_busy,
    output logic [FRS_ADDR_W-FRS_ROW_LOG2-1:0] o_erase_row,
    output logic                           o_latch_reset,
    output logic [FRS_ADDR_W-1:0]          o_latch_blank,
    // interrupt
    output logic                           o_irq
);

    // =====================================================================
    // apb handshake: one wait cycle, answer registered
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        acc;
    logic        wr_acc;
    logic        mapped;

    assign acc    = i_psel & i_penable & pready_r;
    assign wr_acc = acc & i_pwrite;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == FRS_OFS_ADDR_LOW) || (a == FRS_OFS_ADDR_HIGH) ||
                    (a == FRS_OFS_CTRL) || (a == FRS_OFS_UNLOCK) ||
                    (a == FRS_OFS_IRQ_STAT) || (a == FRS_OFS_IRQ_MASK);
    endfunction : is_mapped

    assign mapped = is_mapped(i_paddr);

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            pready_r <= 1'b0;
        else
            pready_r <= i_psel & i_penable & ~pready_r;
    end

    // =====================================================================
    // registers written by software
    logic [FRS_ADDR_LOW_W-1:0]  addr_low_r;
    logic [FRS_ADDR_HIGH_W-1:0] addr_high_r;
    logic                       write_enable_bit_r;
    logic                       free_r;
    logic                       config_space_select_r;
    logic                       rd_r;
    logic                       wr_r;
    logic                       werr_r;
    logic [FRS_IRQ_W-1:0]       irq_stat_r;
    logic [FRS_IRQ_W-1:0]       irq_mask_r;
    frs_key_e                   key_r;
    frs_state_e                 state_r;
    logic [31:0]                cnt_r;
    logic                       ctrl_wr;
    logic                       start_req;
    logic                       start_ok;
    logic                       erase_end;

    assign ctrl_wr   = wr_acc && (i_paddr == FRS_OFS_CTRL);
    assign start_req = ctrl_wr && i_pwdata[FRS_CTRL_WR_BIT] && !wr_r;
    // the ctrl write itself must carry enable and erase select
    assign start_ok  = start_req && (key_r == FRS_KEY_ARMED) &&
                       i_pwdata[FRS_CTRL_WRITE_ENABLE_BIT_BIT] && i_pwdata[FRS_CTRL_FREE_BIT] &&
                       !i_pwdata[FRS_CTRL_CONFIG_SPACE_SELECT_BIT];
    assign erase_end = (state_r == FRS_ST_ERASE) && (cnt_r == 32'(ERASE_CYCLES - 1));

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            addr_low_r  <= '0;
            addr_high_r <= '0;
        end
        else if (wr_acc && state_r == FRS_ST_IDLE)
        begin
            if (i_paddr == FRS_OFS_ADDR_LOW)
                addr_low_r <= i_pwdata[FRS_ADDR_LOW_W-1:0];
            if (i_paddr == FRS_OFS_ADDR_HIGH)
                addr_high_r <= i_pwdata[FRS_ADDR_HIGH_W-1:0];
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            write_enable_bit_r <= 1'b0;
            free_r <= 1'b0;
            config_space_select_r <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            write_enable_bit_r <= i_pwdata[FRS_CTRL_WRITE_ENABLE_BIT_BIT];
            free_r <= i_pwdata[FRS_CTRL_FREE_BIT];
            config_space_select_r <= i_pwdata[FRS_CTRL_CONFIG_SPACE_SELECT_BIT];
        end
    end

    // start bits: software sets only, hardware clears
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            rd_r <= 1'b0;
            wr_r <= 1'b0;
        end
        else
        begin
            rd_r <= ctrl_wr && i_pwdata[FRS_CTRL_RD_BIT] && !rd_r;
            if (start_ok)
                wr_r <= 1'b1;
            else if (erase_end)
                wr_r <= 1'b0;
        end
    end

    // error flag survives a reset that cuts an erase short; a long reset keeps it
    logic rst_q_r;

    always_ff @(posedge i_clk)
    begin
        rst_q_r <= i_sys_rst;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            case (state_r)
                FRS_ST_SETUP, FRS_ST_ERASE:
                    werr_r <= 1'b1;
                FRS_ST_IDLE:
                    if (!rst_q_r)
                        werr_r <= 1'b0;
                default:
                    werr_r <= 1'b0;
            endcase
        end
        else if (ctrl_wr && !i_pwdata[FRS_CTRL_WERR_BIT])
            werr_r <= 1'b0;
    end

    // =====================================================================
    // unlock key tracker: any other write in between disarms it
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            key_r <= FRS_KEY_NONE;
        else if (wr_acc)
        begin
            if (i_paddr == FRS_OFS_UNLOCK && i_pwdata[7:0] == FRS_KEY_FIRST)
                key_r <= FRS_KEY_HALF;
            else if (i_paddr == FRS_OFS_UNLOCK && i_pwdata[7:0] == FRS_KEY_SECOND
                     && key_r == FRS_KEY_HALF)
                key_r <= FRS_KEY_ARMED;
            else
                key_r <= FRS_KEY_NONE;
        end
    end

    // =====================================================================
    // sequencer: set-up, stall, done
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            state_r <= FRS_ST_IDLE;
            cnt_r   <= '0;
        end
        else
        begin
            case (state_r)
                FRS_ST_IDLE:
                begin
                    cnt_r <= '0;
                    if (start_ok)
                        state_r <= FRS_ST_SETUP;
                end
                FRS_ST_SETUP:
                begin
                    if (cnt_r == 32'(FRS_SETUP_CYCLES - 1))
                    begin
                        state_r <= FRS_ST_ERASE;
                        cnt_r   <= '0;
                    end
                    else
                        cnt_r <= cnt_r + 32'd1;
                end
                FRS_ST_ERASE:
                begin
                    if (erase_end)
                        state_r <= FRS_ST_IDLE;
                    else
                        cnt_r <= cnt_r + 32'd1;
                end
                default:
                begin
                    state_r <= FRS_ST_IDLE;
                    cnt_r   <= '0;
                end
            endcase
        end
    end

    // core and array outputs; only the core halts, clock keeps running
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_nop_force   <= 1'b0;
            o_cpu_stall   <= 1'b0;
            o_resume      <= 1'b0;
            o_erase_busy  <= 1'b0;
            o_erase_row   <= '0;
            o_latch_reset <= 1'b0;
        end
        else
        begin
            o_nop_force   <= start_ok || (state_r == FRS_ST_SETUP &&
                             cnt_r != 32'(FRS_SETUP_CYCLES - 1));
            o_cpu_stall   <= (state_r == FRS_ST_SETUP && cnt_r == 32'(FRS_SETUP_CYCLES - 1))
                             || (state_r == FRS_ST_ERASE && !erase_end);
            o_resume      <= erase_end;
            o_erase_busy  <= (state_r == FRS_ST_SETUP && cnt_r == 32'(FRS_SETUP_CYCLES - 1))
                             || (state_r == FRS_ST_ERASE && !erase_end);
            if (start_ok)
                o_erase_row <= {addr_high_r, addr_low_r[FRS_ADDR_LOW_W-1:FRS_ROW_LOG2]};
            o_latch_reset <= erase_end;
        end
    end

    assign o_latch_blank = FRS_LATCH_BLANK;

    // =====================================================================
    // interrupts: sticky, write one to clear, set wins
    logic [FRS_IRQ_W-1:0] irq_set;
    logic [FRS_IRQ_W-1:0] irq_clr;
    logic                 irq_r;

    assign irq_set = {start_req && !start_ok, erase_end};
    assign irq_clr = (wr_acc && i_paddr == FRS_OFS_IRQ_STAT) ? i_pwdata[FRS_IRQ_W-1:0] : '0;

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            irq_stat_r <= '0;
        else
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            irq_mask_r <= '0;
        else if (wr_acc && i_paddr == FRS_OFS_IRQ_MASK)
            irq_mask_r <= i_pwdata[FRS_IRQ_W-1:0];
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            irq_r <= 1'b0;
        else
            irq_r <= |((((irq_stat_r & ~irq_clr) | irq_set)) & irq_mask_r);
    end

    assign o_irq = irq_r;

    // =====================================================================
    // read data
    logic [31:0] rd_word;

    always_comb
    begin
        rd_word = FRS_ZERO_WORD;
        case (i_paddr)
            FRS_OFS_ADDR_LOW:  rd_word[FRS_ADDR_LOW_W-1:0] = addr_low_r;
            FRS_OFS_ADDR_HIGH: rd_word[FRS_ADDR_HIGH_W-1:0] = addr_high_r;
            FRS_OFS_CTRL:
            begin
                rd_word[FRS_CTRL_RD_BIT]   = rd_r;
                rd_word[FRS_CTRL_WR_BIT]   = wr_r;
                rd_word[FRS_CTRL_WRITE_ENABLE_BIT_BIT] = write_enable_bit_r;
                rd_word[FRS_CTRL_WERR_BIT] = werr_r;
                rd_word[FRS_CTRL_FREE_BIT] = free_r;
                rd_word[FRS_CTRL_BUSY_BIT] = (state_r != FRS_ST_IDLE);
                rd_word[FRS_CTRL_CONFIG_SPACE_SELECT_BIT] = config_space_select_r;
            end
            FRS_OFS_UNLOCK:    rd_word = FRS_ZERO_WORD;
            FRS_OFS_IRQ_STAT:  rd_word[FRS_IRQ_W-1:0] = irq_stat_r;
            FRS_OFS_IRQ_MASK:  rd_word[FRS_IRQ_W-1:0] = irq_mask_r;
            default:           rd_word = FRS_ZERO_WORD;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            prdata_r  <= FRS_ZERO_WORD;
            pslverr_r <= 1'b0;
        end
        else
        begin
            prdata_r  <= (i_psel && i_penable && !pready_r && !i_pwrite) ? rd_word : FRS_ZERO_WORD;
            pslverr_r <= i_psel && i_penable && !pready_r && !mapped;
        end
    end

    assign o_pready  = pready_r;
    assign o_prdata  = prdata_r;
    assign o_pslverr = pslverr_r;

    // =====================================================================
    // assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_start_needs_key: assert property ($rose(o_nop_force) |->
        $past(key_r) == FRS_KEY_ARMED)
        else $error("erase started without armed unlock");
    a_no_start_bad: assert property ((start_req && !i_pwdata[FRS_CTRL_WRITE_ENABLE_BIT_BIT])
        |=> state_r == FRS_ST_IDLE)
        else $error("erase started without write enable");
    a_setup_two: assert property (start_ok |=>
        o_nop_force ##1 o_nop_force ##1 o_cpu_stall)
        else $error("set-up cycles not two");
    a_stall_held: assert property ($rose(o_cpu_stall) |-> o_cpu_stall [*8])
        else $error("stall dropped early");
    a_resume_pulse: assert property (erase_end |=>
        o_resume && !o_cpu_stall ##1 !o_resume)
        else $error("resume not a single pulse after erase");
    a_wr_cleared: assert property (erase_end |=> !wr_r && state_r == FRS_ST_IDLE)
        else $error("write start not cleared at end");
    a_wr_sw_set: assert property ($rose(wr_r) |-> $past(start_ok))
        else $error("write start set without a valid start");
    a_latch_blank: assert property (o_latch_reset |-> $past(erase_end) && o_resume)
        else $error("latch reset not tied to erase end");
    a_unlock_zero: assert property ((acc && !i_pwrite && i_paddr == FRS_OFS_UNLOCK)
        |-> rd_word == FRS_ZERO_WORD)
        else $error("unlock register read not zero");
    a_row_fixed: assert property (o_erase_busy |=> $stable(o_erase_row))
        else $error("row changed during erase");

    c_erase_done:  cover property (erase_end ##1 o_resume);
    c_bad_key:     cover property (start_req && key_r != FRS_KEY_ARMED);
    c_irq_raised:  cover property ($rose(o_irq));
    c_unlock_read: cover property (acc && !i_pwrite && i_paddr == FRS_OFS_UNLOCK);

endmodule : frs_flash_row_erase

// ---- hdl/frs_pkg.sv ----
// constants and types of the flash row erase sequencer
// assumes a 50 MHz system clock and an apb master on the same clock
// Behaviour
// - while running code, program memory is erased only as whole rows
// - the whole row holding the loaded address is erased, any word within
// - unlock key 55h then AAh in order; only then may erase start
// - setting write start after valid unlock with erase selected begins erase
// - two set-up cycles follow the write start before the stall
// - instruction execution halts for the erase time, typically 2 ms
// - clocks and peripherals keep running during the stall, no sleep
// - execution resumes at the third instruction after write start
// - start bits are set only by software, cleared by hardware at end
// - reset during an erase sets the write error flag
// - unlock register is write only and reads zero
// - every erase end resets write latches to blank 3FFF
package frs_pkg;

    // =====================================================================
    // register map (byte addresses)
    localparam logic [7:0] FRS_OFS_ADDR_LOW  = 8'h00;
    localparam logic [7:0] FRS_OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] FRS_OFS_CTRL      = 8'h08;
    localparam logic [7:0] FRS_OFS_UNLOCK    = 8'h0C;
    localparam logic [7:0] FRS_OFS_IRQ_STAT  = 8'h10;
    localparam logic [7:0] FRS_OFS_IRQ_MASK  = 8'h14;

    // =====================================================================
    // control register fields
    localparam int FRS_CTRL_RD_BIT   = 0;
    localparam int FRS_CTRL_WR_BIT   = 1;
    localparam int FRS_CTRL_WRITE_ENABLE_BIT_BIT = 2;
    localparam int FRS_CTRL_WERR_BIT = 3;
    localparam int FRS_CTRL_FREE_BIT = 4;
    localparam int FRS_CTRL_BUSY_BIT = 5;
    localparam int FRS_CTRL_CONFIG_SPACE_SELECT_BIT = 6;

    // interrupt status fields
    localparam int FRS_IRQ_DONE_BIT   = 0;
    localparam int FRS_IRQ_REFUSE_BIT = 1;
    localparam int FRS_IRQ_W          = 2;

    // =====================================================================
    // widths, keys, reset values
    localparam int          FRS_ADDR_LOW_W = 8;
    localparam int          FRS_ADDR_HIGH_W = 6;
    localparam int          FRS_ADDR_W     = 14;
    localparam int          FRS_ROW_LOG2   = 4;
    localparam logic [7:0]  FRS_KEY_FIRST  = 8'h55;
    localparam logic [7:0]  FRS_KEY_SECOND = 8'hAA;
    localparam logic [13:0] FRS_LATCH_BLANK = 14'h3FFF;
    localparam logic [31:0] FRS_ZERO_WORD  = 32'h0000_0000;

    // =====================================================================
    // timing
    localparam int FRS_CLK_PERIOD_NS = 20;
    localparam int FRS_ERASE_TIME_NS = 2000000;
    localparam int FRS_ERASE_CYCLES  = FRS_ERASE_TIME_NS / FRS_CLK_PERIOD_NS;
    localparam int FRS_SETUP_CYCLES  = 2;

    // =====================================================================
    // sequencer states
    typedef enum logic [2:0] {
        FRS_ST_IDLE  = 3'b001,
        FRS_ST_SETUP = 3'b010,
        FRS_ST_ERASE = 3'b100
    } frs_state_e;

    // unlock progress
    typedef enum logic [2:0] {
        FRS_KEY_NONE  = 3'b001,
        FRS_KEY_HALF  = 3'b010,
        FRS_KEY_ARMED = 3'b100
    } frs_key_e;

endpackage : frs_pkg

// ---- test/frs_core_model.sv ----
// core software model: issues apb transfers and unlock sequences to the sequencer
// assumes one clock shared with the sequencer and an answer within a bounded wait
`timescale 1ns/1ps
module frs_core_model
    import frs_pkg::*;
(
    // clock
    input  wire logic        i_clk,
    // apb master
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [7:0]       o_paddr,
    output logic [31:0]      o_pwdata,
    input  wire logic        i_pready,
    input  wire logic [31:0] i_prdata
);
    initial
    begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = 8'h00;
        o_pwdata  = 32'h0000_0000;
    end

    // =====================================================================
    // one transfer; ok stays low when no answer comes within the bound
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic ok);
        int n;
        ok    = 1'b0;
        rdata = 32'h0000_0000;
        @(posedge i_clk);
        o_psel    <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite  <= wr;
        o_paddr   <= addr;
        o_pwdata  <= wdata;
        @(posedge i_clk);
        o_penable <= 1'b1;
        for (n = 0; n < 16 && !ok; n++)
        begin
            @(posedge i_clk);
            ok    = (i_pready === 1'b1);
            rdata = i_prdata;
        end
        // released address and data lines carry the inverse, never the old value
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        o_paddr   <= ~addr;
        o_pwdata  <= ~wdata;
    endtask : xfer

    // =====================================================================
    // interrupts are assumed off: key pair and start go out unbroken
    task automatic start_seq(input logic [31:0] k1, input logic [31:0] k2,
                             input logic [31:0] ctrl, output logic ok);
        logic [31:0] rd;
        logic        a;
        logic        b;
        logic        c;
        xfer(1'b1, FRS_OFS_UNLOCK, k1, rd, a);
        xfer(1'b1, FRS_OFS_UNLOCK, k2, rd, b);
        xfer(1'b1, FRS_OFS_CTRL, ctrl, rd, c);
        ok = a & b & c;
    endtask : start_seq
endmodule : frs_core_model

// ---- test/tb_top.sv ----
// testbench of the flash row erase sequencer with a scoreboard on apb reads
// assumes the core model drives the apb side; erase time shortened to 20 cycles
`timescale 1ns/1ps
module tb_top;
    import frs_pkg::*;
    localparam int          ERASE_N    = 20;
    localparam logic [31:0] CTRL_ERASE = 32'h0000_0016;
    logic [31:0] bad_k1 [4] = '{32'h55, 32'hAA, 32'h55, 32'h55};
    logic [31:0] bad_k2 [4] = '{32'hAA, 32'h55, 32'h55, 32'hAA};
    logic [31:0] bad_c  [4] = '{32'h12, CTRL_ERASE, CTRL_ERASE, 32'h56};
    logic        i_clk;
    logic        i_sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        nop_force;
    logic        cpu_stall;
    logic        resume;
    logic        erase_busy;
    logic [9:0]  erase_row;
    logic        latch_reset;
    logic [13:0] latch_blank;
    logic        irq;
    logic [32:0] exp_q [$];
    int          err_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          t0;
    int          i;
    logic [31:0] a;
    logic        ok;
    logic        seen;

    initial i_clk = 1'b0;
    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;

    frs_flash_row_erase #(.ERASE_CYCLES(ERASE_N)) DUT (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .o_nop_force(nop_force),
        .o_cpu_stall(cpu_stall), .o_resume(resume), .o_erase_busy(erase_busy),
        .o_erase_row(erase_row), .o_latch_reset(latch_reset),
        .o_latch_blank(latch_blank), .o_irq(irq));

    frs_core_model u_core (
        .i_clk(i_clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata), .i_pready(pready), .i_prdata(prdata));

    // =====================================================================
    // checking and closing
    task automatic chk(input string name, input logic [32:0] seen_v, input logic [32:0] exp_v);
        check_count++;
        if (seen_v !== exp_v)
        begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp_v, seen_v);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    task automatic lost();
        err_count++;
        $display("wait bound ran out");
        end_sim();
    endtask : lost

    // scoreboard: oldest note against every read answer
    always @(posedge i_clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            if (exp_q.size() == 0)
                chk("unexpected read", 33'h0, 33'h1);
            else
                chk("read data", {pslverr, prdata}, exp_q.pop_front());
        end
    end

    // =====================================================================
    // bus and wait helpers
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] r;
        logic        k;
        u_core.xfer(1'b1, ad, d, r, k);
        if (!k) lost();
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [32:0] e);
        logic [31:0] r;
        logic        k;
        exp_q.push_back(e);
        u_core.xfer(1'b0, ad, 32'h0, r, k);
        if (!k) lost();
    endtask : rd

    task automatic wait_hi(input bit on_resume);
        int n;
        #1;
        for (n = 0; n < 60 && (on_resume ? resume : cpu_stall) !== 1'b1; n++)
            @(posedge i_clk) #1;
        if (n == 60) lost();
    endtask : wait_hi

    // =====================================================================
    initial
    begin
        i_sys_rst = 1'b1;
        void'($urandom(74931));
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        // reset values, write-only key, unmapped places, address widths
        for (i = 0; i < 6; i++) rd(8'(4 * i), 33'h0);
        rd(8'h18, 33'h1_0000_0000);
        wr(FRS_OFS_UNLOCK, 32'h55);
        rd(FRS_OFS_UNLOCK, 33'h0);
        a = $urandom;
        wr(FRS_OFS_ADDR_LOW, a);
        wr(FRS_OFS_ADDR_HIGH, a);
        rd(FRS_OFS_ADDR_LOW, 33'(a[7:0]));
        rd(FRS_OFS_ADDR_HIGH, 33'(a[5:0]));
        $display("test 1 done");
        // good erase: walk of set-up, stall, resume
        wr(FRS_OFS_IRQ_MASK, 32'h3);
        a = $urandom;
        wr(FRS_OFS_ADDR_LOW, 32'(a[7:0]));
        wr(FRS_OFS_ADDR_HIGH, 32'(a[13:8]));
        u_core.start_seq(32'h55, 32'hAA, CTRL_ERASE, ok);
        if (!ok) lost();
        #1;
        chk("nop slot 1", {nop_force, cpu_stall}, 33'h2);
        @(posedge i_clk) #1;
        chk("nop slot 2", {nop_force, cpu_stall}, 33'h2);
        @(posedge i_clk) #1;
        chk("stall start", {nop_force, cpu_stall, erase_busy}, 33'h3);
        chk("erase row", erase_row, 33'(a[13:4]));
        t0 = cyc;
        rd(FRS_OFS_CTRL, 33'h36);
        wait_hi(1'b1);
        chk("stall length", 33'(cyc - t0), 33'(ERASE_N));
        chk("resume", {cpu_stall, erase_busy, latch_reset}, 33'h1);
        chk("blank", latch_blank, 33'(FRS_LATCH_BLANK));
        @(posedge i_clk) #1;
        chk("irq done", {irq, resume}, 33'h2);
        rd(FRS_OFS_CTRL, 33'h14);
        rd(FRS_OFS_IRQ_STAT, 33'h1);
        wr(FRS_OFS_IRQ_STAT, 32'h1);
        rd(FRS_OFS_IRQ_STAT, 33'h0);
        $display("test 2 done");
        // refused starts, masked and unmasked
        for (i = 0; i < 4; i++)
        begin
            wr(FRS_OFS_IRQ_MASK, i[0] ? 32'h3 : 32'h0);
            u_core.start_seq(bad_k1[i], bad_k2[i], bad_c[i], ok);
            if (!ok) lost();
            #1 seen = nop_force | cpu_stall;
            repeat (4) @(posedge i_clk) #1 seen = seen | nop_force | cpu_stall;
            chk("refused start", seen, 33'h0);
            rd(FRS_OFS_IRQ_STAT, 33'h2);
            chk("irq level", irq, 33'(i[0]));
            wr(FRS_OFS_IRQ_STAT, 32'h3);
            rd(FRS_OFS_IRQ_STAT, 33'h0);
        end
        $display("test 3 done");
        // reset in mid-erase leaves the write error flag
        u_core.start_seq(32'h55, 32'hAA, CTRL_ERASE, ok);
        if (!ok) lost();
        wait_hi(1'b0);
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1;
        chk("stall after reset", {cpu_stall, erase_busy, irq}, 33'h0);
        rd(FRS_OFS_CTRL, 33'h8);
        wr(FRS_OFS_CTRL, 32'h1);
        rd(FRS_OFS_CTRL, 33'h0);
        $display("test 4 done");
        end_sim();
    end
endmodule : tb_top
